// ---- src/rpc_pkg.sv ----
// Purpose: Shared constants and types for the packet configuration bank.
// Assumes: 8-bit registers on a plain strobe port, one clock.
// Notes: Offsets are byte addresses on the host port.
`default_nettype none
package rpc_pkg;
	localparam logic [7:0] RPC_OFS_SYNC_THIRD = 8'h18;
	localparam logic [7:0] RPC_OFS_SYNC_FOURTH = 8'h19;
	localparam logic [7:0] RPC_OFS_TX_PARAM = 8'h1A;
	localparam logic [7:0] RPC_OFS_CLK_OUT = 8'h1B;
	localparam logic [7:0] RPC_OFS_PAYLOAD = 8'h1C;
	localparam logic [7:0] RPC_OFS_NODE_ADDR = 8'h1D;
	localparam logic [7:0] RPC_OFS_PKT_CFG = 8'h1E;
	localparam logic [7:0] RPC_OFS_FIFO_CRC = 8'h1F;
	localparam logic [7:0] RPC_OFS_SYNC_FIRST = 8'h16;
	localparam logic [7:0] RPC_OFS_SYNC_SECOND = 8'h17;

	localparam logic [7:0] RPC_RST_SYNC = 8'h00;
	localparam logic [7:0] RPC_RST_TX_PARAM = 8'h7C;
	localparam logic [7:0] RPC_RST_CLK_OUT = 8'hBC;
	localparam logic [7:0] RPC_RST_PAYLOAD = 8'h00;
	localparam logic [7:0] RPC_RST_NODE_ADDR = 8'h00;
	localparam logic [7:0] RPC_RST_PKT_CFG = 8'h48;
	localparam logic [7:0] RPC_RST_FIFO_CRC = 8'h00;

	// Writable bit masks; reserved and read-only bits stay out.
	localparam logic [7:0] RPC_WMASK_TX_PARAM = 8'hFE;
	localparam logic [7:0] RPC_WMASK_CLK_OUT = 8'hFC;
	localparam logic [7:0] RPC_WMASK_PKT_CFG = 8'hFE;
	localparam logic [7:0] RPC_WMASK_FIFO_CRC = 8'hC0;

	localparam int RPC_POS_CRC_OK = 0;
	localparam logic [7:0] RPC_ADDR_ZERO = 8'h00;
	localparam logic [7:0] RPC_ADDR_BCAST = 8'hFF;
	localparam logic [4:0] RPC_DIV_BYPASS = 5'h00;

	typedef enum logic [1:0] {
		RPC_AF_OFF = 2'h0,
		RPC_AF_NODE = 2'h1,
		RPC_AF_NODE_ZERO = 2'h2,
		RPC_AF_NODE_ZERO_BCAST = 2'h3
	} rpc_af_mode_t;

	typedef struct packed {
		logic [3:0] tx_interp_filter_cutoff;
		logic [2:0] tx_output_power_code;
		logic clock_output_enable;
		logic [4:0] clock_output_divider;
		logic manchester_enable;
		logic [6:0] payload_length;
		logic [7:0] local_node_address;
		logic length_format_select;
		logic [1:0] preamble_length;
		logic whitening_enable;
		logic crc_enable;
		rpc_af_mode_t address_filter_mode;
		logic fifo_autoclear_on_bad_crc;
		logic [31:0] sync_word_value;
	} rpc_cfg_t;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
	} rpc_rx_addr_t;
endpackage : rpc_pkg
`default_nettype wire

// ---- src/rpc_addr_filter.sv ----
// Purpose: Accept or reject a received address by filter mode.
// Assumes: Address byte arrives with a one-cycle valid.
// Notes: Verdict is registered, one cycle after valid.
`default_nettype none
module rpc_addr_filter (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire rpc_pkg::rpc_af_mode_t mode, // filter mode
	input wire logic [7:0] node_addr, // local node address
	input wire rpc_pkg::rpc_rx_addr_t rx_addr, // received address
	output logic accept_ff, // verdict pulse: accepted
	output logic reject_ff // verdict pulse: rejected
);
	import rpc_pkg::*;
	logic nxt_ok;

	always_comb begin
		unique case (mode)
			RPC_AF_OFF: nxt_ok = 1'b1;
			RPC_AF_NODE: nxt_ok = (rx_addr.addr == node_addr);
			RPC_AF_NODE_ZERO: nxt_ok = (rx_addr.addr == node_addr) ||
				(rx_addr.addr == RPC_ADDR_ZERO);
			RPC_AF_NODE_ZERO_BCAST: nxt_ok = (rx_addr.addr == node_addr) ||
				(rx_addr.addr == RPC_ADDR_ZERO) ||
				(rx_addr.addr == RPC_ADDR_BCAST);
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			accept_ff <= 1'b0;
			reject_ff <= 1'b0;
		end else begin
			accept_ff <= rx_addr.valid && nxt_ok;
			reject_ff <= rx_addr.valid && !nxt_ok;
		end
	end
endmodule : rpc_addr_filter
`default_nettype wire

// ---- src/rpc_clk_div.sv ----
// Purpose: Clock output divider from the crystal reference.
// Assumes: The reference is clk itself.
// Notes: Division by 2*N yields a square wave of N high, N low.
`default_nettype none
module rpc_clk_div (
	input wire logic clk, // crystal reference clock
	input wire logic nrst, // async reset, active low
	input wire logic enable, // clock output enable
	input wire logic [4:0] divider, // divider code
	output logic clk_out // divided clock, low when disabled
);
	import rpc_pkg::*;
	logic [4:0] cnt_ff;
	logic phase_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= 5'h00;
			phase_ff <= 1'b0;
		end else if (!enable || divider == RPC_DIV_BYPASS) begin
			cnt_ff <= 5'h00;
			phase_ff <= 1'b0;
		end else if (cnt_ff >= divider - 5'h01) begin
			cnt_ff <= 5'h00;
			phase_ff <= !phase_ff;
		end else begin
			cnt_ff <= cnt_ff + 5'h01;
		end
	end

	// Bypass passes the reference straight through; a glitch can occur
	// when the code changes, so change it only while disabled.
	assign clk_out = !enable ? 1'b0 :
		(divider == RPC_DIV_BYPASS) ? clk : phase_ff;
endmodule : rpc_clk_div
`default_nettype wire

// ---- src/rpc_regs.sv ----
// Purpose: Packet and transmit configuration register bank.
// Assumes: Host port with one-cycle strobes, read data one cycle later.
// Notes: Packet engine reports CRC results and address bytes here.
`default_nettype none
module rpc_regs (
	input wire logic clk, // system clock, 100 MHz
	input wire logic nrst, // async reset, active low
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic crc_done, // pulse: received packet CRC checked
	input wire logic crc_pass, // CRC verdict beside crc_done
	input wire rpc_pkg::rpc_rx_addr_t rx_addr, // received address byte
	input wire logic [6:0] rx_len, // received length byte
	input wire logic rx_len_valid, // pulse: rx_len valid
	output rpc_pkg::rpc_cfg_t cfg, // configuration to datapath
	output logic [2:0] preamble_bytes, // preamble bytes minus one
	output logic [6:0] tx_length, // payload bytes sent, fixed format
	output logic rx_len_reject, // pulse: length above maximum
	output logic addr_accept, // pulse: address passed filter
	output logic addr_reject, // pulse: packet rejected by address
	output logic fifo_flush, // pulse: clear FIFO after bad CRC
	output logic clk_out // clock output pin
);
	import rpc_pkg::*;

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0] sync_first_ff, sync_second_ff;
	logic [7:0] sync_third_ff, sync_fourth_ff;
	logic [7:0] tx_param_ff, clk_out_ff, payload_ff;
	logic [7:0] node_addr_ff, pkt_cfg_ff, fifo_crc_ff;
	logic crc_ok_ff;
	logic [7:0] rdata_ff, nxt_rdata;
	logic fifo_flush_ff, rx_len_reject_ff;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	function automatic logic [7:0] masked(input logic [7:0] old,
		input logic [7:0] wd, input logic [7:0] m);
		masked = (old & ~m) | (wd & m);
	endfunction : masked

	// ----------------------------------------------------------------
	// Sync word bytes
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_first_ff <= RPC_RST_SYNC;
			sync_second_ff <= RPC_RST_SYNC;
			sync_third_ff <= RPC_RST_SYNC;
			sync_fourth_ff <= RPC_RST_SYNC;
		end else if (reg_wr) begin
			if (hit(reg_addr, RPC_OFS_SYNC_FIRST)) begin
				sync_first_ff <= reg_wdata;
			end
			if (hit(reg_addr, RPC_OFS_SYNC_SECOND)) begin
				sync_second_ff <= reg_wdata;
			end
			if (hit(reg_addr, RPC_OFS_SYNC_THIRD)) begin
				sync_third_ff <= reg_wdata;
			end
			if (hit(reg_addr, RPC_OFS_SYNC_FOURTH)) begin
				sync_fourth_ff <= reg_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit and clock output registers
	// ----------------------------------------------------------------
	// Reserved low bits are masked so they always read zero.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_param_ff <= RPC_RST_TX_PARAM;
			clk_out_ff <= RPC_RST_CLK_OUT;
		end else if (reg_wr) begin
			if (hit(reg_addr, RPC_OFS_TX_PARAM)) begin
				tx_param_ff <= masked(tx_param_ff, reg_wdata,
					RPC_WMASK_TX_PARAM);
			end
			if (hit(reg_addr, RPC_OFS_CLK_OUT)) begin
				clk_out_ff <= masked(clk_out_ff, reg_wdata,
					RPC_WMASK_CLK_OUT);
			end
		end
	end

	// ----------------------------------------------------------------
	// Packet registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			payload_ff <= RPC_RST_PAYLOAD;
			node_addr_ff <= RPC_RST_NODE_ADDR;
			pkt_cfg_ff <= RPC_RST_PKT_CFG;
			fifo_crc_ff <= RPC_RST_FIFO_CRC;
		end else if (reg_wr) begin
			if (hit(reg_addr, RPC_OFS_PAYLOAD)) begin
				payload_ff <= reg_wdata;
			end
			if (hit(reg_addr, RPC_OFS_NODE_ADDR)) begin
				node_addr_ff <= reg_wdata;
			end
			if (hit(reg_addr, RPC_OFS_PKT_CFG)) begin
				pkt_cfg_ff <= masked(pkt_cfg_ff, reg_wdata,
					RPC_WMASK_PKT_CFG);
			end
			if (hit(reg_addr, RPC_OFS_FIFO_CRC)) begin
				fifo_crc_ff <= masked(fifo_crc_ff, reg_wdata,
					RPC_WMASK_FIFO_CRC);
			end
		end
	end

	// ----------------------------------------------------------------
	// CRC status and FIFO auto clear
	// ----------------------------------------------------------------
	// The status bit follows each check while CRC is enabled; host writes cannot touch it.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			crc_ok_ff <= 1'b0;
		end else if (crc_done && cfg.crc_enable) begin
			crc_ok_ff <= crc_pass;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fifo_flush_ff <= 1'b0;
		end else begin
			fifo_flush_ff <= crc_done && cfg.crc_enable && !crc_pass &&
				!cfg.fifo_autoclear_on_bad_crc;
		end
	end

	// ----------------------------------------------------------------
	// Received length check
	// ----------------------------------------------------------------
	// Only variable format carries a length byte worth checking.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_len_reject_ff <= 1'b0;
		end else begin
			rx_len_reject_ff <= rx_len_valid && cfg.length_format_select &&
				(rx_len > cfg.payload_length);
		end
	end

	// ----------------------------------------------------------------
	// Field decode to the datapath
	// ----------------------------------------------------------------
	always_comb begin
		cfg.tx_interp_filter_cutoff = tx_param_ff[7:4];
		cfg.tx_output_power_code = tx_param_ff[3:1];
		cfg.clock_output_enable = clk_out_ff[7];
		cfg.clock_output_divider = clk_out_ff[6:2];
		cfg.manchester_enable = payload_ff[7];
		cfg.payload_length = payload_ff[6:0];
		cfg.local_node_address = node_addr_ff;
		cfg.length_format_select = pkt_cfg_ff[7];
		cfg.preamble_length = pkt_cfg_ff[6:5];
		cfg.whitening_enable = pkt_cfg_ff[4];
		cfg.crc_enable = pkt_cfg_ff[3];
		cfg.address_filter_mode = rpc_af_mode_t'(pkt_cfg_ff[2:1]);
		cfg.fifo_autoclear_on_bad_crc = fifo_crc_ff[7];
		cfg.sync_word_value = {sync_first_ff, sync_second_ff,
			sync_third_ff, sync_fourth_ff};
	end

	assign preamble_bytes = {1'b0, cfg.preamble_length};
	// Variable format ignores the field on transmit.
	assign tx_length = cfg.length_format_select ? 7'h00 :
		cfg.payload_length;
	assign fifo_flush = fifo_flush_ff;
	assign rx_len_reject = rx_len_reject_ff;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		nxt_rdata = 8'h00;
		unique case (reg_addr)
			RPC_OFS_SYNC_FIRST: nxt_rdata = sync_first_ff;
			RPC_OFS_SYNC_SECOND: nxt_rdata = sync_second_ff;
			RPC_OFS_SYNC_THIRD: nxt_rdata = sync_third_ff;
			RPC_OFS_SYNC_FOURTH: nxt_rdata = sync_fourth_ff;
			RPC_OFS_TX_PARAM: nxt_rdata = tx_param_ff;
			RPC_OFS_CLK_OUT: nxt_rdata = clk_out_ff;
			RPC_OFS_PAYLOAD: nxt_rdata = payload_ff;
			RPC_OFS_NODE_ADDR: nxt_rdata = node_addr_ff;
			RPC_OFS_PKT_CFG: nxt_rdata = {pkt_cfg_ff[7:1], crc_ok_ff};
			RPC_OFS_FIFO_CRC: nxt_rdata = fifo_crc_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign reg_rdata = rdata_ff;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	rpc_addr_filter u_filter (
		.clk(clk),
		.nrst(nrst),
		.mode(cfg.address_filter_mode),
		.node_addr(cfg.local_node_address),
		.rx_addr(rx_addr),
		.accept_ff(addr_accept),
		.reject_ff(addr_reject)
	);

	rpc_clk_div u_clkdiv (
		.clk(clk),
		.nrst(nrst),
		.enable(cfg.clock_output_enable),
		.divider(cfg.clock_output_divider),
		.clk_out(clk_out)
	);
endmodule : rpc_regs
`default_nettype wire

// ---- verif/rpc_regs_sva.sv ----
// Purpose: Port assertions for the packet configuration bank.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Sees only the bank's ports; attached by the bind below.
`default_nettype none
module rpc_regs_sva (
	input wire logic clk, // clock
	input wire logic nrst, // reset, active low
	input wire logic [7:0] reg_addr, // address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic crc_done, // crc checked
	input wire logic crc_pass, // crc verdict
	input wire rpc_pkg::rpc_rx_addr_t rx_addr, // rx address
	input wire logic [6:0] rx_len, // rx length
	input wire logic rx_len_valid, // rx length valid
	input wire rpc_pkg::rpc_cfg_t cfg, // decoded fields
	input wire logic [2:0] preamble_bytes, // preamble code
	input wire logic [6:0] tx_length, // tx length
	input wire logic rx_len_reject, // length reject
	input wire logic addr_accept, // address accept
	input wire logic addr_reject, // address reject
	input wire logic fifo_flush, // fifo flush
	input wire logic clk_out // clock output
);
	import rpc_pkg::*;
	logic hit;
	// Verdict the filter should give for the address now offered.
	assign hit = cfg.address_filter_mode == RPC_AF_OFF
		|| rx_addr.addr == cfg.local_node_address
		|| (cfg.address_filter_mode[1] && rx_addr.addr == RPC_ADDR_ZERO)
		|| (cfg.address_filter_mode == RPC_AF_NODE_ZERO_BCAST
		&& rx_addr.addr == RPC_ADDR_BCAST);
	// ------------------------------------------
	// Assertions
	// ------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_sync_third_wr: assert property (reg_wr && reg_addr == 8'h18
		|=> cfg.sync_word_value[15:8] == $past(reg_wdata))
		else $error("sync third byte not stored");
	a_sync_fourth_wr: assert property (reg_wr && reg_addr == 8'h19
		|=> cfg.sync_word_value[7:0] == $past(reg_wdata))
		else $error("sync fourth byte not stored");
	a_tx_fields_wr: assert property (reg_wr && reg_addr == 8'h1A
		|=> {cfg.tx_interp_filter_cutoff, cfg.tx_output_power_code}
		== $past(reg_wdata[7:1]))
		else $error("transmit fields not stored");
	a_preamble_code: assert property (
		preamble_bytes == {1'b0, cfg.preamble_length})
		else $error("preamble code wrong");
	a_tx_length_fmt: assert property (tx_length ==
		(cfg.length_format_select ? 7'h00 : cfg.payload_length))
		else $error("tx length wrong");
	a_len_reject: assert property (rx_len_reject == $past(
		rx_len_valid && cfg.length_format_select
		&& rx_len > cfg.payload_length))
		else $error("length reject wrong");
	a_filter_verdict: assert property (rx_addr.valid |=>
		addr_accept == $past(hit) && addr_reject == !$past(hit))
		else $error("filter verdict wrong");
	a_verdict_idle: assert property (!rx_addr.valid |=>
		!addr_accept && !addr_reject)
		else $error("verdict without address");
	a_flush_bad_crc: assert property (fifo_flush == $past(
		crc_done && !crc_pass && cfg.crc_enable
		&& !cfg.fifo_autoclear_on_bad_crc))
		else $error("fifo flush wrong");
	a_clk_out_off: assert property (!cfg.clock_output_enable
		&& !$past(cfg.clock_output_enable) |-> !clk_out)
		else $error("clock output not off");
	a_bypass_follows: assert property (@(negedge clk) disable iff (!nrst)
		cfg.clock_output_enable
		&& cfg.clock_output_divider == RPC_DIV_BYPASS |-> clk_out)
		else $error("bypass clock not passed");
endmodule : rpc_regs_sva

bind rpc_regs rpc_regs_sva u_sva (.clk(clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.crc_done(crc_done), .crc_pass(crc_pass), .rx_addr(rx_addr),
	.rx_len(rx_len), .rx_len_valid(rx_len_valid), .cfg(cfg),
	.preamble_bytes(preamble_bytes), .tx_length(tx_length),
	.rx_len_reject(rx_len_reject), .addr_accept(addr_accept),
	.addr_reject(addr_reject), .fifo_flush(fifo_flush), .clk_out(clk_out));
`default_nettype wire

// ---- verif/test_rpc_regs.sv ----
// Purpose: Self-checking bench for the packet configuration bank.
// Assumes: Bench is the host and the packet engine at once.
// Notes: Tasks return just after a rising edge.
`default_nettype none
module test_rpc_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import rpc_pkg::*;
	logic clk, nrst, reg_wr, reg_rd, crc_done, crc_pass, rx_len_valid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v, d;
	logic [6:0] rx_len, tx_length;
	logic [2:0] preamble_bytes;
	logic [3:0] cap;
	logic rx_len_reject, addr_accept, addr_reject, fifo_flush, clk_out;
	logic crc_st;
	rpc_rx_addr_t rx_addr;
	rpc_cfg_t cfg;
	integer seed;
	int miscompares, check_count, i, j, n;
	localparam logic [7:0] RADR [7] = '{8'h18, 8'h19, 8'h1A, 8'h1B,
		8'h1C, 8'h1D, 8'h1E};
	localparam logic [7:0] RRST [7] = '{8'h00, 8'h00, 8'h7C, 8'hBC,
		8'h00, 8'h00, 8'h48};
	localparam logic [7:0] RXA [4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};

	rpc_regs dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .crc_done(crc_done), .crc_pass(crc_pass),
		.rx_addr(rx_addr), .rx_len(rx_len), .rx_len_valid(rx_len_valid),
		.cfg(cfg), .preamble_bytes(preamble_bytes), .tx_length(tx_length),
		.rx_len_reject(rx_len_reject), .addr_accept(addr_accept),
		.addr_reject(addr_reject), .fifo_flush(fifo_flush),
		.clk_out(clk_out));

	function automatic logic [7:0] exp_rd(input logic [7:0] a, dv);
		case (a)
		RPC_OFS_TX_PARAM: return dv & RPC_WMASK_TX_PARAM;
		RPC_OFS_CLK_OUT: return dv & RPC_WMASK_CLK_OUT;
		RPC_OFS_PKT_CFG: return (dv & RPC_WMASK_PKT_CFG) | {7'h00, crc_st};
		RPC_OFS_FIFO_CRC: return dv & RPC_WMASK_FIFO_CRC;
		8'h20: return 8'h00;
		default: return dv;
		endcase
	endfunction : exp_rd

	function automatic logic exp_hit(input logic [1:0] m, logic [7:0] a);
		return m == 2'h0 || a == 8'h5A || (m[1] && a == 8'h00)
			|| (m == 2'h3 && a == 8'hFF);
	endfunction : exp_hit

	task chk(input string nm, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Strobes stay as set; the next call overrides them.
	task cyc(input logic w, r, input logic [7:0] a, dv);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= dv;
		@(posedge clk);
	endtask : cyc

	task wr(input logic [7:0] a, dv);
		cyc(1'b1, 1'b0, a, dv);
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] q);
		cyc(1'b0, 1'b1, a, 8'h00);
		reg_rd <= 1'b0;
		@(negedge clk);
		q = reg_rdata;
		@(posedge clk);
	endtask : rd

	task evt(input logic cd, cp, av, input logic [7:0] a,
		input logic lv, input logic [6:0] ln);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		crc_done <= cd;
		crc_pass <= cp;
		rx_addr <= '{av, a};
		rx_len_valid <= lv;
		rx_len <= ln;
		@(posedge clk);
		crc_done <= 1'b0;
		rx_addr.valid <= 1'b0;
		rx_len_valid <= 1'b0;
		@(negedge clk);
		cap = {addr_accept, addr_reject, fifo_flush, rx_len_reject};
		@(posedge clk);
	endtask : evt

	task conclude;
		if (miscompares == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#100000;
		miscompares++;
		conclude();
	end

	initial begin
		seed = 45540;
		crc_st = 1'b0;
		nrst = 1'b0;
		{reg_wr, reg_rd, crc_done, crc_pass, rx_len_valid} = 5'h00;
		{reg_addr, reg_wdata, rx_len} = 23'h0;
		rx_addr = '0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		for (i = 0; i < 7; i++) begin
			rd(RADR[i], v);
			chk("reset value", RRST[i], v);
		end
		for (j = 0; j < 6; j++) begin
			for (i = 0; i < 8; i++) begin
				d = 8'($random(seed));
				if (i == 2)
					d &= RPC_WMASK_TX_PARAM;
				if (i == 3)
					d &= RPC_WMASK_CLK_OUT;
				wr(i < 7 ? RADR[i] : 8'h20, d);
				rd(i < 7 ? RADR[i] : 8'h20, v);
				chk("readback", exp_rd(i < 7 ? RADR[i] : 8'h20, d), v);
			end
		end
		wr(RPC_OFS_NODE_ADDR, 8'h5A);
		for (i = 0; i < 4; i++) begin
			wr(RPC_OFS_PKT_CFG, {1'b0, i[1:0], i[0], 1'b1, i[1:0], 1'b0});
			for (j = 0; j < 4; j++) begin
				evt(1'b0, 1'b0, 1'b1, RXA[j], 1'b0, 7'h00);
				chk("verdict", {6'h00, exp_hit(i[1:0], RXA[j]),
					!exp_hit(i[1:0], RXA[j])}, {6'h00, cap[3:2]});
			end
			chk("preamble", {6'h00, i[1:0]}, {5'h00, preamble_bytes});
		end
		for (i = 0; i < 8; i++) begin
			wr(RPC_OFS_PKT_CFG, {4'h4, i[2], 3'b000});
			wr(RPC_OFS_FIFO_CRC, {i[1], 7'h7F});
			evt(1'b1, i[0], 1'b0, 8'h00, 1'b0, 7'h00);
			chk("flush", {7'h00, i[2] & !i[1] & !i[0]}, {7'h00, cap[1]});
			if (i[2])
				crc_st = i[0];
			rd(RPC_OFS_PKT_CFG, v);
			chk("crc status", exp_rd(RPC_OFS_PKT_CFG, {4'h4, i[2], 3'b000}), v);
		end
		wr(RPC_OFS_PAYLOAD, 8'h20);
		wr(RPC_OFS_PKT_CFG, 8'hC8);
		evt(1'b0, 1'b0, 1'b0, 8'h00, 1'b1, 7'h20);
		chk("len equal", 8'h00, {7'h00, cap[0]});
		chk("tx len var", 8'h00, {1'b0, tx_length});
		evt(1'b0, 1'b0, 1'b0, 8'h00, 1'b1, 7'h21);
		chk("len over", 8'h01, {7'h00, cap[0]});
		wr(RPC_OFS_PKT_CFG, 8'h48);
		evt(1'b0, 1'b0, 1'b0, 8'h00, 1'b1, 7'h7F);
		chk("len fixed", 8'h00, {7'h00, cap[0]});
		chk("tx len fix", 8'h20, {1'b0, tx_length});
		wr(RPC_OFS_CLK_OUT, 8'h8C);
		cyc(1'b0, 1'b0, 8'h00, 8'h00);
		for (n = 0; n < 50 && clk_out !== 1'b0; n++) @(negedge clk);
		for (n = 0; n < 50 && clk_out !== 1'b1; n++) @(negedge clk);
		for (n = 0; n < 50 && clk_out === 1'b1; n++) @(negedge clk);
		chk("high run", 8'h03, n[7:0]);
		@(posedge clk);
		wr(RPC_OFS_CLK_OUT, 8'h0C);
		cyc(1'b0, 1'b0, 8'h00, 8'h00);
		repeat (2) @(posedge clk);
		n = 0;
		repeat (20) begin
			@(negedge clk);
			n += int'(clk_out !== 1'b0);
		end
		chk("clock off", 8'h00, n[7:0]);
		@(posedge clk);
		wr(RPC_OFS_CLK_OUT, 8'h80);
		cyc(1'b0, 1'b0, 8'h00, 8'h00);
		repeat (2) @(negedge clk);
		n = 0;
		repeat (20) begin
			@(clk);
			#1;
			n += int'(clk_out !== clk);
		end
		chk("bypass", 8'h00, n[7:0]);
		@(posedge clk);
		conclude();
	end
endmodule : test_rpc_regs
`default_nettype wire
